//--- core/cbmd_decoder.v
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cbmd_defines.vh"
module cbmd_decoder (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr
);
    // byte feed: software writes instruction bytes one at a time
    localparam ST_OP = 6'b000001;
    localparam ST_MODRM = 6'b000010;
    localparam ST_DISP = 6'b000100;
    localparam ST_IMM = 6'b001000;
    localparam ST_DONE = 6'b010000;
    localparam ST_SEG = 6'b100000;

    reg [5:0] state_r;
    reg [7:0] op_r;
    reg [7:0] modrm_r;
    reg [15:0] disp_r;
    reg [15:0] imm_r;
    reg [1:0] disp_left_r;
    reg [2:0] imm_left_r;
    reg disp_idx_r;
    reg imm_idx_r;
    reg [5:0] class_r;
    reg [15:0] psw_r;
    reg [15:0] count_r;
    reg [15:0] base_r;
    reg [15:0] frame_r;
    reg [15:0] src_r;
    reg [15:0] dst_r;
    reg [1:0] seg_ovr_r;
    reg seg_ovr_vld_r;
    reg [1:0] seg_r;
    reg taken_r;
    reg illegal_r;
    reg [1:0] modrm_need_disp;

    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;
    wire feed = wr & (paddr == `CBMD_ADDR_BYTE);
    wire [7:0] b = pwdata[7:0];
    wire mapped = (paddr == `CBMD_ADDR_CTRL) | (paddr == `CBMD_ADDR_BYTE) |
        (paddr == `CBMD_ADDR_PSW) | (paddr == `CBMD_ADDR_REGS) |
        (paddr == `CBMD_ADDR_BASE) | (paddr == `CBMD_ADDR_IDX) |
        (paddr == `CBMD_ADDR_INFO) | (paddr == `CBMD_ADDR_EA) |
        (paddr == `CBMD_ADDR_DISP) | (paddr == `CBMD_ADDR_IMM) |
        (paddr == `CBMD_ADDR_CLASS);

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    wire cf = psw_r[`CBMD_PSW_CF];
    wire pf = psw_r[`CBMD_PSW_PF];
    wire zf = psw_r[`CBMD_PSW_ZF];
    wire sf = psw_r[`CBMD_PSW_SF];
    wire of = psw_r[`CBMD_PSW_OF];

    // condition of a short conditional jump
    reg cond;
    always @* begin
        case (op_r[3:1])
            3'd0: cond = of;
            3'd1: cond = cf;
            3'd2: cond = zf;
            3'd3: cond = cf | zf;
            3'd4: cond = sf;
            3'd5: cond = pf;
            3'd6: cond = sf ^ of;
            default: cond = (sf ^ of) | zf;
        endcase
    end
    wire jcc_take = cond ^ op_r[0];
    wire [15:0] cnt_dec = count_r - 16'h0001;

    // opcode classification
    reg [5:0] cls;
    reg [1:0] op_imm;
    reg op_has_modrm;
    always @* begin
        cls = `CBMD_CL_NONE;
        op_imm = 2'd0;
        op_has_modrm = 1'b0;
        if (b[7:4] == 4'h7) begin
            cls = `CBMD_CL_JCC;
            op_imm = 2'd1;
        end else begin
            case (b)
                `CBMD_OP_JMP_NEAR: begin
                    cls = `CBMD_CL_JMP_NEAR;
                    op_imm = 2'd2;
                end
                `CBMD_OP_JMP_SHORT: begin
                    cls = `CBMD_CL_JMP_SHORT;
                    op_imm = 2'd1;
                end
                `CBMD_OP_JMP_FAR: begin
                    // code 3 stands for offset word plus segment word
                    cls = `CBMD_CL_JMP_FAR;
                    op_imm = 2'd3;
                end
                `CBMD_OP_GRP_FF: op_has_modrm = 1'b1;
                `CBMD_OP_MOV_SEG: op_has_modrm = 1'b1;
                `CBMD_OP_RET: cls = `CBMD_CL_RET;
                `CBMD_OP_RET_IMM: begin
                    cls = `CBMD_CL_RET_IMM;
                    op_imm = 2'd2;
                end
                `CBMD_OP_RETF: cls = `CBMD_CL_RETF;
                `CBMD_OP_RETF_IMM: begin
                    cls = `CBMD_CL_RETF_IMM;
                    op_imm = 2'd2;
                end
                `CBMD_OP_LOOP: begin
                    cls = `CBMD_CL_LOOP;
                    op_imm = 2'd1;
                end
                `CBMD_OP_LOOPZ: begin
                    cls = `CBMD_CL_LOOPZ;
                    op_imm = 2'd1;
                end
                `CBMD_OP_LOOPNZ: begin
                    cls = `CBMD_CL_LOOPNZ;
                    op_imm = 2'd1;
                end
                `CBMD_OP_JCZ: begin
                    cls = `CBMD_CL_JCZ;
                    op_imm = 2'd1;
                end
                `CBMD_OP_INT: begin
                    cls = `CBMD_CL_INT;
                    op_imm = 2'd1;
                end
                `CBMD_OP_INT3: cls = `CBMD_CL_INT3;
                `CBMD_OP_INTO: cls = `CBMD_CL_INTO;
                `CBMD_OP_INTERRUPT_RETURN: cls = `CBMD_CL_INTERRUPT_RETURN;
                `CBMD_OP_CLC, `CBMD_OP_CMC, `CBMD_OP_STC, `CBMD_OP_CLD,
                `CBMD_OP_STD, `CBMD_OP_CLI, `CBMD_OP_STI, `CBMD_OP_HLT,
                `CBMD_OP_WAIT, `CBMD_OP_LOCK: cls = `CBMD_CL_CTRL;
                default: begin
                    if ({b[7:5], b[2:0]} == 6'b001110)
                        cls = `CBMD_CL_SEGPFX;
                    else
                        cls = `CBMD_CL_NONE;
                end
            endcase
        end
    end

    // displacement bytes implied by the addressing byte
    always @* begin
        case (b[7:6])
            2'b00: modrm_need_disp = (b[2:0] == 3'b110) ? 2'd2 : 2'd0;
            2'b01: modrm_need_disp = 2'd1;
            2'b10: modrm_need_disp = 2'd2;
            default: modrm_need_disp = 2'd0;
        endcase
    end

    // effective address; direct form ignores base registers
    reg [15:0] ea_base;
    always @* begin
        case (modrm_r[2:0])
            3'b000: ea_base = base_r + src_r;
            3'b001: ea_base = base_r + dst_r;
            3'b010: ea_base = frame_r + src_r;
            3'b011: ea_base = frame_r + dst_r;
            3'b100: ea_base = src_r;
            3'b101: ea_base = dst_r;
            3'b110: ea_base = (modrm_r[7:6] == 2'b00) ? 16'h0000 : frame_r;
            default: ea_base = base_r;
        endcase
    end
    wire [15:0] disp_ext = (modrm_r[7:6] == 2'b01) ?
        {{8{disp_r[7]}}, disp_r[7:0]} : disp_r;
    wire [15:0] ea = ea_base + disp_ext;
    wire is_mem = (modrm_r[7:6] != 2'b11);
    wire width_word = op_r[0];
    wire dir_to_reg = op_r[1];
    wire [15:0] imm_sx = {{8{imm_r[7]}}, imm_r[7:0]};
    wire sx_imm = op_r[1] & op_r[0];
    wire [7:0] shift_cnt = op_r[1] ? count_r[7:0] : 8'h01;
    wire rep_go = (op_r[0] == zf);
    // default segment: frame-pointer forms use stack segment
    wire [1:0] def_seg = (modrm_r[2:1] == 2'b01 ||
        (modrm_r[2:0] == 3'b110 && modrm_r[7:6] != 2'b00)) ? 2'b10 : 2'b11;

    // completion of a finished instruction
    reg take_nxt;
    always @* begin
        case (class_r)
            `CBMD_CL_JCC: take_nxt = jcc_take;
            `CBMD_CL_LOOP: take_nxt = (cnt_dec != 16'h0000);
            `CBMD_CL_LOOPZ: take_nxt = (cnt_dec != 16'h0000) & zf;
            `CBMD_CL_LOOPNZ: take_nxt = (cnt_dec != 16'h0000) & ~zf;
            `CBMD_CL_JCZ: take_nxt = (count_r == 16'h0000);
            `CBMD_CL_INTO: take_nxt = of;
            `CBMD_CL_NONE, `CBMD_CL_ILLEGAL, `CBMD_CL_MODRM: take_nxt = 1'b0;
            default: take_nxt = 1'b1;
        endcase
    end
    wire is_loop = (class_r == `CBMD_CL_LOOP) | (class_r == `CBMD_CL_LOOPZ) |
        (class_r == `CBMD_CL_LOOPNZ);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_OP;
            op_r <= 8'h00;
            modrm_r <= 8'h00;
            disp_r <= 16'h0000;
            imm_r <= 16'h0000;
            disp_left_r <= 2'd0;
            imm_left_r <= 3'd0;
            disp_idx_r <= 1'b0;
            imm_idx_r <= 1'b0;
            class_r <= `CBMD_CL_NONE;
            psw_r <= `CBMD_PSW_RESET;
            count_r <= 16'h0000;
            base_r <= 16'h0000;
            frame_r <= 16'h0000;
            src_r <= 16'h0000;
            dst_r <= 16'h0000;
            seg_ovr_r <= 2'b00;
            seg_ovr_vld_r <= 1'b0;
            seg_r <= 2'b11;
            taken_r <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            if (wr && paddr == `CBMD_ADDR_CTRL && pwdata[0])
                state_r <= ST_OP;
            if (wr && paddr == `CBMD_ADDR_PSW)
                psw_r <= pwdata[15:0] & `CBMD_PSW_MASK;
            if (wr && paddr == `CBMD_ADDR_REGS)
                count_r <= pwdata[15:0];
            if (wr && paddr == `CBMD_ADDR_BASE) begin
                base_r <= pwdata[15:0];
                frame_r <= pwdata[31:16];
            end
            if (wr && paddr == `CBMD_ADDR_IDX) begin
                src_r <= pwdata[15:0];
                dst_r <= pwdata[31:16];
            end
            if (state_r == ST_DONE) begin
                taken_r <= take_nxt;
                if (is_loop)
                    count_r <= cnt_dec;
                if (class_r == `CBMD_CL_CTRL) begin
                    case (op_r)
                        `CBMD_OP_CLC: psw_r[`CBMD_PSW_CF] <= 1'b0;
                        `CBMD_OP_CMC: psw_r[`CBMD_PSW_CF] <= ~cf;
                        `CBMD_OP_STC: psw_r[`CBMD_PSW_CF] <= 1'b1;
                        `CBMD_OP_CLD: psw_r[`CBMD_PSW_DF] <= 1'b0;
                        `CBMD_OP_STD: psw_r[`CBMD_PSW_DF] <= 1'b1;
                        `CBMD_OP_CLI: psw_r[`CBMD_PSW_IF] <= 1'b0;
                        `CBMD_OP_STI: psw_r[`CBMD_PSW_IF] <= 1'b1;
                        default: psw_r <= psw_r;
                    endcase
                end
                state_r <= ST_OP;
            end else if (feed) begin
                case (state_r)
                    ST_OP: begin
                        op_r <= b;
                        class_r <= op_has_modrm ? `CBMD_CL_MODRM : cls;
                        disp_r <= 16'h0000;
                        imm_r <= 16'h0000;
                        disp_idx_r <= 1'b0;
                        imm_idx_r <= 1'b0;
                        imm_left_r <= (op_imm == 2'd3) ? 3'd4 :
                            {1'b0, op_imm};
                        illegal_r <= 1'b0;
                        if (cls == `CBMD_CL_SEGPFX) begin
                            seg_ovr_r <= b[4:3];
                            seg_ovr_vld_r <= 1'b1;
                            state_r <= ST_OP;
                        end else if (op_has_modrm)
                            state_r <= ST_MODRM;
                        else if (op_imm != 2'd0)
                            state_r <= ST_IMM;
                        else
                            state_r <= ST_DONE;
                    end
                    ST_MODRM: begin
                        modrm_r <= b;
                        disp_left_r <= modrm_need_disp;
                        seg_r <= seg_ovr_vld_r ? seg_ovr_r :
                            ((b[7:6] == 2'b00 && b[2:0] == 3'b110) ? 2'b11 :
                            ((b[2:1] == 2'b01 || b[2:0] == 3'b110) ?
                            2'b10 : 2'b11));
                        seg_ovr_vld_r <= 1'b0;
                        if (op_r == `CBMD_OP_MOV_SEG) begin
                            illegal_r <= (b[4:3] == 2'b01);
                            class_r <= (b[4:3] == 2'b01) ?
                                `CBMD_CL_ILLEGAL : `CBMD_CL_MODRM;
                        end else if (b[5:3] == 3'b100)
                            class_r <= `CBMD_CL_JMP_IND;
                        else if (b[5:3] == 3'b101)
                            class_r <= `CBMD_CL_JMP_IND_FAR;
                        if (modrm_need_disp != 2'd0)
                            state_r <= ST_DISP;
                        else
                            state_r <= ST_DONE;
                    end
                    ST_DISP: begin
                        if (disp_idx_r)
                            disp_r[15:8] <= b;
                        else
                            disp_r[7:0] <= b;
                        disp_idx_r <= 1'b1;
                        disp_left_r <= disp_left_r - 2'd1;
                        if (disp_left_r == 2'd1)
                            state_r <= (imm_left_r != 3'd0) ? ST_IMM : ST_DONE;
                    end
                    ST_IMM: begin
                        // far form keeps the offset word, segment skipped
                        if (class_r != `CBMD_CL_JMP_FAR ||
                            imm_left_r > 3'd2) begin
                            if (imm_idx_r)
                                imm_r[15:8] <= b;
                            else
                                imm_r[7:0] <= b;
                        end
                        imm_idx_r <= 1'b1;
                        imm_left_r <= imm_left_r - 3'd1;
                        if (imm_left_r == 3'd1)
                            state_r <= ST_DONE;
                    end
                    default: state_r <= ST_OP;
                endcase
            end
        end
    end

    // register read mux
    always @* begin
        prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                `CBMD_ADDR_CTRL: prdata = {26'h0000000, state_r};
                `CBMD_ADDR_PSW: prdata = {16'h0000, psw_r};
                `CBMD_ADDR_REGS: prdata = {16'h0000, count_r};
                `CBMD_ADDR_BASE: prdata = {frame_r, base_r};
                `CBMD_ADDR_IDX: prdata = {dst_r, src_r};
                `CBMD_ADDR_INFO: prdata = {16'h0000, shift_cnt, rep_go,
                    illegal_r, taken_r, is_mem, sx_imm, dir_to_reg,
                    width_word, 1'b0};
                `CBMD_ADDR_EA: prdata = {12'h000, def_seg, seg_r, ea};
                `CBMD_ADDR_DISP: prdata = {16'h0000, disp_ext};
                `CBMD_ADDR_IMM: prdata = {(sx_imm ? imm_sx : imm_r), imm_r};
                `CBMD_ADDR_CLASS: prdata = {8'h00, modrm_r, op_r, 2'b00,
                    class_r};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // cbmd_decoder
`default_nettype wire

//--- core/cbmd_defines.vh
`ifndef CBMD_DEFINES_VH
`define CBMD_DEFINES_VH
// apb register byte addresses
`define CBMD_ADDR_CTRL 12'h000
`define CBMD_ADDR_BYTE 12'h004
`define CBMD_ADDR_PSW 12'h008
`define CBMD_ADDR_REGS 12'h00C
`define CBMD_ADDR_BASE 12'h010
`define CBMD_ADDR_IDX 12'h014
`define CBMD_ADDR_INFO 12'h018
`define CBMD_ADDR_EA 12'h01C
`define CBMD_ADDR_DISP 12'h020
`define CBMD_ADDR_IMM 12'h024
`define CBMD_ADDR_CLASS 12'h028
// status word bit positions
`define CBMD_PSW_CF 0
`define CBMD_PSW_PF 2
`define CBMD_PSW_AF 4
`define CBMD_PSW_ZF 6
`define CBMD_PSW_SF 7
`define CBMD_PSW_TF 8
`define CBMD_PSW_IF 9
`define CBMD_PSW_DF 10
`define CBMD_PSW_OF 11
`define CBMD_PSW_MASK 16'h0FD5
`define CBMD_PSW_RESET 16'h0000
// opcodes
`define CBMD_OP_JMP_NEAR 8'hE9
`define CBMD_OP_JMP_SHORT 8'hEB
`define CBMD_OP_JMP_FAR 8'hEA
`define CBMD_OP_GRP_FF 8'hFF
`define CBMD_OP_RET 8'hC3
`define CBMD_OP_RET_IMM 8'hC2
`define CBMD_OP_RETF 8'hCB
`define CBMD_OP_RETF_IMM 8'hCA
`define CBMD_OP_LOOP 8'hE2
`define CBMD_OP_LOOPZ 8'hE1
`define CBMD_OP_LOOPNZ 8'hE0
`define CBMD_OP_JCZ 8'hE3
`define CBMD_OP_INT 8'hCD
`define CBMD_OP_INT3 8'hCC
`define CBMD_OP_INTO 8'hCE
`define CBMD_OP_INTERRUPT_RETURN 8'hCF
`define CBMD_OP_CLC 8'hF8
`define CBMD_OP_CMC 8'hF5
`define CBMD_OP_STC 8'hF9
`define CBMD_OP_CLD 8'hFC
`define CBMD_OP_STD 8'hFD
`define CBMD_OP_CLI 8'hFA
`define CBMD_OP_STI 8'hFB
`define CBMD_OP_HLT 8'hF4
`define CBMD_OP_WAIT 8'h9B
`define CBMD_OP_LOCK 8'hF0
`define CBMD_OP_MOV_SEG 8'h8E
// decode classes
`define CBMD_CL_NONE 6'h00
`define CBMD_CL_JMP_NEAR 6'h01
`define CBMD_CL_JMP_SHORT 6'h02
`define CBMD_CL_JMP_IND 6'h03
`define CBMD_CL_JMP_FAR 6'h04
`define CBMD_CL_JMP_IND_FAR 6'h05
`define CBMD_CL_RET 6'h06
`define CBMD_CL_RET_IMM 6'h07
`define CBMD_CL_RETF 6'h08
`define CBMD_CL_RETF_IMM 6'h09
`define CBMD_CL_JCC 6'h0A
`define CBMD_CL_LOOP 6'h0B
`define CBMD_CL_LOOPZ 6'h0C
`define CBMD_CL_LOOPNZ 6'h0D
`define CBMD_CL_JCZ 6'h0E
`define CBMD_CL_INT 6'h0F
`define CBMD_CL_INT3 6'h10
`define CBMD_CL_INTO 6'h11
`define CBMD_CL_INTERRUPT_RETURN 6'h12
`define CBMD_CL_CTRL 6'h13
`define CBMD_CL_SEGPFX 6'h14
`define CBMD_CL_ILLEGAL 6'h15
`define CBMD_CL_MODRM 6'h16
`define CBMD_INT3_TYPE 8'h03
`endif

//--- dv/cbmd_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "cbmd_defines.vh"
module cbmd_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic rd;
    logic bad;
    logic psw_v_r;
    logic [15:0] psw_r;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign bad = paddr > `CBMD_ADDR_CLASS;
    // byte or control writes may let decode touch the flags: drop the copy
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psw_v_r <= 1'b1;
            psw_r <= 16'h0000;
        end else if (acc && pwrite && paddr == `CBMD_ADDR_PSW) begin
            psw_v_r <= 1'b1;
            psw_r <= pwdata[15:0];
        end else if (acc && pwrite && paddr < `CBMD_ADDR_PSW) begin
            psw_v_r <= 1'b0;
        end
    end
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_in_access: assert property (pslverr |-> acc)
        else $error("pslverr outside access phase");
    a_err_unmapped: assert property (acc && bad |-> pslverr)
        else $error("unmapped access without pslverr");
    a_ok_mapped: assert property (acc && !bad && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("pslverr on mapped address");
    a_rdata_idle: assert property (!rd |-> prdata == 32'h0)
        else $error("prdata not zero outside read");
    a_bad_reads_zero: assert property (rd && bad |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_psw_layout: assert property (
        rd && paddr == `CBMD_ADDR_PSW |-> (prdata & ~32'h0FD5) == 32'h0)
        else $error("undefined status bits set");
    a_psw_written: assert property (
        rd && paddr == `CBMD_ADDR_PSW && psw_v_r
        |-> prdata[15:0] == (psw_r & `CBMD_PSW_MASK))
        else $error("status word differs from last write");
    c_unmapped: cover property (acc && bad);
    c_psw_read: cover property (rd && paddr == `CBMD_ADDR_PSW && psw_v_r);
    c_class_read: cover property (rd && paddr == `CBMD_ADDR_CLASS);
endmodule // cbmd_checker
bind cbmd_decoder cbmd_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

//--- dv/cbmd_fetch_model.sv
`timescale 1ns/100ps
`default_nettype none
module cbmd_fetch_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // the idle edge after each transfer also spaces instructions apart
    task automatic xfer(input logic wr, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            pwdata <= ~d;
            @(posedge pclk);
        end
    endtask
endmodule // cbmd_fetch_model
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cbmd_defines.vh"
module tb_top;
    logic pclk;
    logic presetn;
    wire logic psel;
    wire logic penable;
    wire logic pwrite;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    int err_count;
    int compares;
    logic [55:0] tab [17] = '{{8'h01, 8'h03, 40'h34_12E9},
        {8'h02, 8'h02, 40'h05EB}, {8'h03, 8'h02, 40'hE0FF},
        {8'h04, 8'h05, 40'h20_0010_00EA}, {8'h05, 8'h02, 40'hE8FF},
        {8'h06, 8'h01, 40'hC3}, {8'h07, 8'h03, 40'h00_08C2},
        {8'h08, 8'h01, 40'hCB}, {8'h09, 8'h03, 40'h00_08CA},
        {8'h0B, 8'h02, 40'h02E2}, {8'h0C, 8'h02, 40'h02E1},
        {8'h0D, 8'h02, 40'h02E0}, {8'h0E, 8'h02, 40'h02E3},
        {8'h0F, 8'h02, 40'h21CD}, {8'h10, 8'h01, 40'hCC},
        {8'h11, 8'h01, 40'hCE}, {8'h12, 8'h01, 40'hCF}};
    logic [7:0] ctl [10] = '{8'hF8, 8'hF5, 8'hF9, 8'hFC, 8'hFD, 8'hFA,
        8'hFB, 8'hF4, 8'h9B, 8'hF0};
    logic [23:0] pt [8] = '{24'hF9_0001, 24'hF5_0000, 24'hF5_0001,
        24'hFD_0401, 24'hFB_0601, 24'hFC_0201, 24'hFA_0001, 24'hF8_0000};
    logic [15:0] fl [4] = '{16'h0000, 16'h0801, 16'h00C4, 16'h0080};
    cbmd_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    cbmd_fetch_model i_fetch (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    always #5 pclk = ~pclk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        i_fetch.xfer(1'b1, a, d, q, e);
    endtask
    task rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        i_fetch.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task start;
        wr(`CBMD_ADDR_CTRL, 32'h1);
    endtask
    task feed(input logic [39:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            wr(`CBMD_ADDR_BYTE, {24'h0, b[8*i +: 8]});
        end
    endtask
    function automatic logic cc(input logic [3:0] c, input logic [15:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = f[11];
            3'h1: r = f[0];
            3'h2: r = f[6];
            3'h3: r = f[0] | f[6];
            3'h4: r = f[7];
            3'h5: r = f[2];
            3'h6: r = f[7] ^ f[11];
            default: r = (f[7] ^ f[11]) | f[6];
        endcase
        return r ^ c[0];
    endfunction
    task t_bus;
        logic [31:0] q;
        logic e;
        rd(`CBMD_ADDR_PSW, q);
        chk(q, 32'h0);
        i_fetch.xfer(1'b0, 12'h030, 32'h0, q, e);
        chk(q, 32'h0);
        chk(32'(e), 32'h1);
        wr(`CBMD_ADDR_PSW, 32'hFFFF_FFFF);
        rd(`CBMD_ADDR_PSW, q);
        chk(q, 32'h0FD5);
        $display("bus test done");
    endtask
    task t_cls;
        logic [31:0] q;
        for (int k = 0; k < 27; k++) begin
            start();
            if (k < 17) feed(tab[k][39:0], int'(tab[k][47:40]));
            else feed({32'h0, ctl[k-17]}, 1);
            rd(`CBMD_ADDR_CLASS, q);
            chk(32'(q[5:0]), k < 17 ? 32'(tab[k][55:48]) : 32'h13);
        end
        $display("class test done");
    endtask
    task t_jcc;
        logic [31:0] q;
        for (int f = 0; f < 4; f++) for (int c = 0; c < 16; c++) begin
            start();
            wr(`CBMD_ADDR_PSW, {16'h0, fl[f]});
            feed({24'h0, 8'hFE, 4'h7, c[3:0]}, 2);
            rd(`CBMD_ADDR_CLASS, q);
            chk(32'(q[5:0]), 32'h0A);
            rd(`CBMD_ADDR_INFO, q);
            chk(32'(q[5]), 32'(cc(c[3:0], fl[f])));
        end
        $display("condition test done");
    endtask
    task lp(input logic [15:0] n, input logic [15:0] f, input logic [7:0] op,
            input logic [15:0] en, input logic et);
        logic [31:0] q;
        start();
        wr(`CBMD_ADDR_REGS, {16'h0, n});
        wr(`CBMD_ADDR_PSW, {16'h0, f});
        feed({24'h0, 8'h10, op}, op == 8'hCE ? 1 : 2);
        rd(`CBMD_ADDR_REGS, q);
        chk(32'(q[15:0]), 32'(en));
        rd(`CBMD_ADDR_INFO, q);
        chk(32'(q[5]), 32'(et));
    endtask
    task ea(input logic [39:0] b, input int n, input logic [15:0] e,
            input logic [15:0] d, input logic m);
        logic [31:0] q;
        start();
        wr(`CBMD_ADDR_BASE, 32'h2000_1000);
        wr(`CBMD_ADDR_IDX, 32'h0300_0040);
        feed(b, n);
        rd(`CBMD_ADDR_INFO, q);
        chk(32'(q[4]), 32'(m));
        if (m) begin
            rd(`CBMD_ADDR_EA, q);
            chk(32'(q[15:0]), 32'(e));
            rd(`CBMD_ADDR_DISP, q);
            chk(32'(q[15:0]), 32'(d));
        end
    endtask
    task t_ea;
        logic [31:0] q;
        ea(40'h80_60FF, 3, 16'h0FC0, 16'hFF80, 1'b1);
        ea(40'h01_67FF, 3, 16'h1001, 16'h0001, 1'b1);
        ea(40'h12_34A6FF, 4, 16'h3234, 16'h1234, 1'b1);
        ea(40'hFF_FEA3FF, 4, 16'h22FE, 16'hFFFE, 1'b1);
        ea(40'h56_7826FF, 4, 16'h5678, 16'h5678, 1'b1);
        ea(40'h25FF, 2, 16'h0300, 16'h0000, 1'b1);
        ea(40'hE3FF, 2, 16'h0000, 16'h0000, 1'b0);
        for (int s = 0; s < 4; s++) begin
            start();
            feed({32'h5678_26FF, 3'h1, s[1:0], 3'h6}, 5);
            rd(`CBMD_ADDR_EA, q);
            chk(32'(q[17:0]), {14'h0, s[1:0], 16'h5678});
        end
        $display("address test done");
    endtask
    task t_ctl;
        logic [31:0] q;
        start();
        wr(`CBMD_ADDR_PSW, 32'h0);
        for (int k = 0; k < 8; k++) begin
            start();
            feed({32'h0, pt[k][23:16]}, 1);
            rd(`CBMD_ADDR_PSW, q);
            chk(q, {16'h0, pt[k][15:0]});
        end
        start();
        feed(40'hC8_8E, 2);
        rd(`CBMD_ADDR_CLASS, q);
        chk(32'(q[5:0]), 32'h15);
        start();
        feed(40'hD8_8E, 2);
        rd(`CBMD_ADDR_INFO, q);
        chk(32'(q[6]), 32'h0);
        $display("control test done");
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        err_count = 0;
        compares = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_bus();
        t_cls();
        t_jcc();
        lp(16'h0001, 16'h0000, 8'hE2, 16'h0000, 1'b0);
        lp(16'h0000, 16'h0000, 8'hE2, 16'hFFFF, 1'b1);
        lp(16'h0000, 16'h0000, 8'hE3, 16'h0000, 1'b1);
        lp(16'h0005, 16'h0000, 8'hE3, 16'h0005, 1'b0);
        lp(16'h0002, 16'h0040, 8'hE1, 16'h0001, 1'b1);
        lp(16'h0002, 16'h0000, 8'hE1, 16'h0001, 1'b0);
        lp(16'h0002, 16'h0040, 8'hE0, 16'h0001, 1'b0);
        lp(16'h0003, 16'h0800, 8'hCE, 16'h0003, 1'b1);
        $display("loop test done");
        t_ea();
        t_ctl();
        tally_and_finish();
    end
    // far longer than the whole sequence needs
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
